// [design/bitset_decode.sv]
// Decode and execute of the bit-set and flag-mask instructions behind an APB slave.
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Flag-mask instruction makes flags[7:4] = old flags[7:4] OR instruction[7:4].
// - Each mask bit 1 forces its flag to 1; 0 keeps it.
// - Flag-mask touches no other flag bit, D and H included, and raises nothing.
// - Parity and overflow share one flags bit, set by one mask position.
// - Flag-mask word is 0x8D high byte, mask nibble, then 0001 low nibble.
// - Indirect pointer is a word register in compact, longword otherwise.
// - General-operand static form consumes one to three extension words before executing.
// - Bit set writes 1 into selected bit only; dynamic form uses registers.
// - Bit number uses low 3, 4 or 5 bits for byte, word, long.
module bitset_decode
	import bitset_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	//////////////////////////////////////////////////////////////////////////////
	// Register and state declarations.
	state_t state_r, state_nxt;
	size_t size_r, size_nxt;
	form_t form_r, form_nxt;
	logic long_r, long_nxt;
	logic [3:0] dst_r, dst_nxt;
	logic [3:0] src_r, src_nxt;
	logic [4:0] bn_r, bn_nxt;
	logic [1:0] ext_r, ext_nxt;
	logic [1:0] ext_seen_r, ext_seen_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic ill_r, ill_nxt;
	logic ptr_long_r, ptr_long_nxt;
	logic [31:0] mem_opnd_r, mem_opnd_nxt;
	logic [31:0] mem_res_r, mem_res_nxt;
	logic [31:0] ea_r, ea_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic gpr_rd_ok_r, gpr_rd_ok_nxt;
	logic rf_we;
	logic [3:0] rf_waddr, rf_raddr;
	logic [31:0] rf_wdata, rf_rdata;
	logic [15:0] w;
	logic is_gpr, accept, wr_instr, apb_done, apb_wait;
	logic [4:0] bn_mask, pos;
	logic [31:0] bit_one, status;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	gpr_file #(.WIDTH(32), .DEPTH(16), .AW(4)) u_gpr (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(rf_we),
		.wr_addr(rf_waddr),
		.wr_data(rf_wdata),
		.rd_addr(rf_raddr),
		.rd_data_r(rf_rdata)
	);

	//////////////////////////////////////////////////////////////////////////////
	// APB decode. Every transfer takes one wait state; register-file accesses wait
	// longer while the decoder is busy, instruction words only while it reads or executes.
	always_comb begin
		w = pwdata[15:0];
		is_gpr = (paddr[7:6] == GPR_WIN);
		apb_wait = psel && penable && !pready_r;
		apb_done = psel && penable && pready_r;
		if (paddr == OFF_INSTR && pwrite) begin
			accept = (state_r == S_OPCODE) || (state_r == S_LONG_OP) || (state_r == S_DYN_DST) || (state_r == S_EXT);
		end else if (is_gpr) begin
			accept = (state_r == S_OPCODE) && gpr_rd_ok_r;
		end else begin
			accept = 1'b1;
		end
		wr_instr = apb_done && pwrite && (paddr == OFF_INSTR);
		status = '0;
		status[ST_BUSY] = (state_r != S_OPCODE);
		status[ST_ILLEGAL] = ill_r;
		status[ST_SIZE +: 2] = size_r;
		status[ST_FORM +: 2] = form_r;
		status[ST_PTR_LONG] = ptr_long_r;
		status[ST_EXT +: 2] = ext_seen_r;
	end

	// Bit position: size mask first, then the high-byte offset for byte registers 0..7.
	always_comb begin
		unique case (size_r)
			SZ_BYTE: bn_mask = BN_BYTE;
			SZ_WORD: bn_mask = BN_WORD;
			default: bn_mask = BN_LONG;
		endcase
		pos = bn_r & bn_mask;
		if (form_r != FM_IND && form_r != FM_EAM && size_r == SZ_BYTE && !dst_r[3]) begin
			pos = pos + BYTE_HI_OFS;
		end
		bit_one = 32'h0000_0001 << pos;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Decoder and execution sequencer.
	always_comb begin
		state_nxt = state_r;
		size_nxt = size_r;
		form_nxt = form_r;
		long_nxt = long_r;
		dst_nxt = dst_r;
		src_nxt = src_r;
		bn_nxt = bn_r;
		ext_nxt = ext_r;
		ext_seen_nxt = ext_seen_r;
		flags_nxt = flags_r;
		ill_nxt = ill_r;
		ptr_long_nxt = ptr_long_r;
		mem_res_nxt = mem_res_r;
		ea_nxt = ea_r;
		rf_we = 1'b0;
		rf_waddr = dst_r;
		rf_wdata = rf_rdata | bit_one;
		rf_raddr = paddr[5:2];
		unique case (state_r)
			S_OPCODE, S_LONG_OP: begin
				if (wr_instr) begin
					long_nxt = 1'b0;
					state_nxt = S_OPCODE;
					if (state_r == S_OPCODE && w[15:8] == OPC_FLAG_HI && w[3:0] == OPC_FLAG_LO) begin
						// Only the four upper bits can rise; D, H and the rest stay as they were.
						flags_nxt = flags_r | ({w[7:4], 4'h0} & FLAGS_SET_MASK);
					end else if (state_r == S_OPCODE && w[15:8] == OPC_LONG_PFX) begin
						long_nxt = 1'b1;
						state_nxt = S_LONG_OP;
					end else begin
						// W selects byte or word; after the prefix the same bit is bit number bit 4.
						size_nxt = long_r ? SZ_LONG : (w[8] ? SZ_WORD : SZ_BYTE);
						bn_nxt = long_r ? {w[8], w[3:0]} : {1'b0, w[3:0]};
						dst_nxt = w[7:4];
						ext_seen_nxt = 2'h0;
						if (w[15:9] == OPC_SET_R) begin
							form_nxt = FM_REG;
							state_nxt = S_READ_DST;
						end else if (w[15:9] == OPC_SET_IR && w[7:4] != REG_NONE) begin
							form_nxt = FM_IND;
							state_nxt = S_READ_DST;
						end else if (w[15:9] == OPC_SET_IR) begin
							// Pointer field zero is not an indirect form; it marks the dynamic form.
							form_nxt = FM_DYN;
							src_nxt = w[3:0];
							state_nxt = S_DYN_DST;
						end else if (w[15:9] == OPC_SET_EAM) begin
							form_nxt = FM_EAM;
							ext_nxt = (w[5:4] == 2'h0) ? 2'h1 : w[5:4];
							ea_nxt = '0;
							state_nxt = S_EXT;
						end else begin
							ill_nxt = 1'b1;
						end
					end
				end
			end
			S_DYN_DST: begin
				if (wr_instr) begin
					dst_nxt = w[11:8];
					state_nxt = S_READ_SRC;
				end
			end
			S_EXT: begin
				// Each extension word shifts into the effective-address holder.
				if (wr_instr) begin
					ea_nxt = {ea_r[15:0], w};
					ext_seen_nxt = ext_seen_r + 2'h1;
					ext_nxt = ext_r - 2'h1;
					if (ext_r == 2'h1) begin
						state_nxt = S_EXEC;
					end
				end
			end
			S_READ_SRC: begin
				rf_raddr = src_r;
				state_nxt = S_READ_DST;
			end
			S_READ_DST: begin
				// Both register forms use the byte-register mapping, so the read and the later write hit one entry.
				rf_raddr = ((form_r == FM_REG || form_r == FM_DYN) && size_r == SZ_BYTE) ? {1'b0, dst_r[2:0]} : dst_r;
				if (form_r == FM_DYN) begin
					bn_nxt = rf_rdata[4:0];
				end
				state_nxt = S_EXEC;
			end
			S_EXEC: begin
				state_nxt = S_OPCODE;
				long_nxt = 1'b0;
				if (form_r == FM_REG || form_r == FM_DYN) begin
					rf_we = 1'b1;
					rf_waddr = (size_r == SZ_BYTE) ? {1'b0, dst_r[2:0]} : dst_r;
				end else begin
					mem_res_nxt = mem_opnd_r | bit_one;
					if (form_r == FM_IND) begin
						ptr_long_nxt = (mode_r != MODE_COMPACT);
						ea_nxt = (mode_r == MODE_COMPACT) ? {16'h0000, rf_rdata[15:0]} : rf_rdata;
					end
				end
			end
			default: state_nxt = S_OPCODE;
		endcase
		// Register-file writes complete only when the decoder is idle, so they never meet an update here.
		if (apb_done && pwrite && is_gpr) begin
			rf_we = 1'b1;
			rf_waddr = paddr[5:2];
			rf_wdata = pwdata;
		end
		if (apb_done && pwrite && paddr == OFF_FLAGS) begin
			flags_nxt = pwdata[7:0];
		end
		if (apb_done && pwrite && paddr == OFF_STATUS && pwdata[ST_ILLEGAL]) begin
			ill_nxt = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// APB answer and software-owned registers.
	always_comb begin
		pready_nxt = 1'b0;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		mode_nxt = mode_r;
		mem_opnd_nxt = mem_opnd_r;
		// The registered read port needed the address through the previous cycle too.
		gpr_rd_ok_nxt = (state_r == S_OPCODE) && (state_nxt == S_OPCODE);
		if (apb_wait && accept) begin
			pready_nxt = 1'b1;
			prdata_nxt = '0;
			if (is_gpr) begin
				prdata_nxt = rf_rdata;
			end else begin
				unique case (paddr)
					OFF_INSTR: prdata_nxt = '0;
					OFF_FLAGS: prdata_nxt = {24'h000000, flags_r};
					OFF_MODE: prdata_nxt = {30'h0, mode_r};
					OFF_STATUS: prdata_nxt = status;
					OFF_MEM_OPND: prdata_nxt = mem_opnd_r;
					OFF_MEM_RES: prdata_nxt = mem_res_r;
					OFF_EA: prdata_nxt = ea_r;
					default: pslverr_nxt = 1'b1;
				endcase
			end
		end
		if (apb_done && pwrite && paddr == OFF_MODE) begin
			mode_nxt = pwdata[1:0];
		end
		if (apb_done && pwrite && paddr == OFF_MEM_OPND) begin
			mem_opnd_nxt = pwdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// State registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= S_OPCODE;
			size_r <= SZ_BYTE;
			form_r <= FM_REG;
			long_r <= 1'b0;
			dst_r <= '0;
			src_r <= '0;
			bn_r <= '0;
			ext_r <= '0;
			ext_seen_r <= '0;
			flags_r <= FLAGS_RST;
			mode_r <= MODE_COMPACT;
			ill_r <= 1'b0;
			ptr_long_r <= 1'b0;
			mem_opnd_r <= '0;
			mem_res_r <= '0;
			ea_r <= '0;
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			gpr_rd_ok_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			size_r <= size_nxt;
			form_r <= form_nxt;
			long_r <= long_nxt;
			dst_r <= dst_nxt;
			src_r <= src_nxt;
			bn_r <= bn_nxt;
			ext_r <= ext_nxt;
			ext_seen_r <= ext_seen_nxt;
			flags_r <= flags_nxt;
			mode_r <= mode_nxt;
			ill_r <= ill_nxt;
			ptr_long_r <= ptr_long_nxt;
			mem_opnd_r <= mem_opnd_nxt;
			mem_res_r <= mem_res_nxt;
			ea_r <= ea_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			gpr_rd_ok_r <= gpr_rd_ok_nxt;
		end
	end
endmodule : bitset_decode
`default_nettype wire

// [design/bitset_pkg.sv]
// Shared constants and types for the bit-set and flag-set decode block.
`default_nettype none
package bitset_pkg;
	// Register byte offsets on the APB slave.
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_MODE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MEM_OPND = 8'h10;
	localparam logic [7:0] OFF_MEM_RES = 8'h14;
	localparam logic [7:0] OFF_EA = 8'h18;
	// General registers occupy 0x40..0x7C, one word each.
	localparam logic [1:0] GPR_WIN = 2'h1;
	// Opcode fields.
	localparam logic [7:0] OPC_FLAG_HI = 8'h8D;
	localparam logic [3:0] OPC_FLAG_LO = 4'h1;
	localparam logic [7:0] OPC_LONG_PFX = 8'h7A;
	localparam logic [6:0] OPC_SET_R = 7'h52;
	localparam logic [6:0] OPC_SET_IR = 7'h12;
	localparam logic [6:0] OPC_SET_EAM = 7'h32;
	localparam logic [3:0] REG_NONE = 4'h0;
	// Flags register: bits 7:4 are C, Z, S and the shared P/V bit; 3 is D, 2 is H.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] FLAGS_SET_MASK = 8'hF0;
	// Addressing modes held in MODE.
	localparam logic [1:0] MODE_COMPACT = 2'h0;
	localparam logic [1:0] MODE_SEGMENTED = 2'h1;
	localparam logic [1:0] MODE_LINEAR = 2'h2;
	// Bit-number masks per operand size and offset of the high byte register.
	localparam logic [4:0] BN_BYTE = 5'h07;
	localparam logic [4:0] BN_WORD = 5'h0F;
	localparam logic [4:0] BN_LONG = 5'h1F;
	localparam logic [4:0] BYTE_HI_OFS = 5'h08;
	// Status register bit positions.
	localparam int ST_BUSY = 0;
	localparam int ST_ILLEGAL = 1;
	localparam int ST_SIZE = 2;
	localparam int ST_FORM = 4;
	localparam int ST_PTR_LONG = 6;
	localparam int ST_EXT = 8;
	localparam logic [31:0] ST_ILLEGAL_MASK = 32'h0000_0002;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
	typedef enum logic [1:0] {FM_REG, FM_DYN, FM_IND, FM_EAM} form_t;
	typedef enum logic [2:0] {S_OPCODE, S_LONG_OP, S_DYN_DST, S_EXT, S_READ_SRC, S_READ_DST, S_EXEC} state_t;
endpackage : bitset_pkg
`default_nettype wire

// [design/gpr_file.sv]
// General register file with one write port and a registered read port.
`default_nettype none
module gpr_file #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_r
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_nxt;

	// Read data is looked up here and registered below, so it lags the address by one cycle.
	always_comb begin
		rd_data_nxt = mem[rd_addr];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_r <= '0;
		end else begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// Storage has no reset so that it maps onto plain memory.
	always_ff @(posedge pclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end
endmodule : gpr_file
`default_nettype wire

// [testbench/bitset_decode_assertions.sv]
// Checker for the APB answers and the flags of the bit-set decode block.
`default_nettype none
module bitset_decode_assertions
	import bitset_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic done;
	logic mapped;
	logic fmask;
	// Completed transfers and what they address.
	assign done = psel && penable && pready;
	assign mapped = paddr[7:6] == GPR_WIN || (paddr[7:6] == 2'h0 && paddr[5:2] < 4'h7 && paddr[1:0] == 2'h0);
	assign fmask = pwrite && paddr == OFF_INSTR && pwdata[15:8] == OPC_FLAG_HI && pwdata[3:0] == OPC_FLAG_LO;
	// Shadow flags; a bad low nibble must not count as a mask word.
	always_comb begin
		flags_nxt = flags_r;
		if (done && pwrite && paddr == OFF_FLAGS) begin
			flags_nxt = pwdata[7:0];
		end else if (done && fmask) begin
			flags_nxt = flags_r | {pwdata[7:4], 4'h0};
		end
	end
	// Register the shadow.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= FLAGS_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
	a_ready_wait: assert property ($rose(penable) |-> !pready) else $error("no wait state");
	a_ready_bound: assert property (psel && penable |-> ##[0:60] pready) else $error("no answer");
	a_err_only_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_err_unmapped: assert property (done && !mapped |-> pslverr && (pwrite || prdata == '0)) else $error("bad hole");
	a_err_mapped: assert property (done && mapped |-> !pslverr) else $error("error on mapped place");
	a_flag_or: assert property (done && !pwrite && paddr == OFF_FLAGS |-> prdata[7:4] == flags_r[7:4])
		else $error("flag set wrong");
	a_flag_keep: assert property (done && !pwrite && paddr == OFF_FLAGS |-> prdata[3:0] == flags_r[3:0])
		else $error("low flags moved");
endmodule : bitset_decode_assertions
bind bitset_decode bitset_decode_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// [testbench/bitset_decode_tb.sv]
// Self-checking bench for the bit-set decode block.
`default_nettype none
module bitset_decode_tb;
	import bitset_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat, v, o;
	logic [31:0] g [16];
	int errors, samples_checked, i, k, sz, rd, rs, t, bn, pos, dyn;
	bitset_decode u_bitset_decode (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	// Free-running core clock.
	always #4 pclk = ~pclk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic tmo(input logic hit);
		if (hit) begin
			errors++;
			give_verdict();
		end
	endtask : tmo
	// One APB transfer; the idle edge first keeps two requests from touching psel in one step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 60);
		tmo(pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Results are only stable once the decoder says it is idle.
	task automatic idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 0);
			n++;
		end while (rdat[ST_BUSY] !== 1'b0 && n < 20);
		tmo(rdat[ST_BUSY] !== 1'b0);
	endtask : idle
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		errors = 0;
		samples_checked = 0;
		v = $urandom(98795);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_FLAGS, 0);
		chk(rdat, {24'h0, FLAGS_RST}, "reset flags");
		apb(1'b0, OFF_STATUS, 0);
		chk(rdat, 0, "reset status");
		// Every mask over random old flags, D and H included.
		for (i = 0; i < 16; i++) begin
			v = $urandom & 32'hFF;
			apb(1'b1, OFF_FLAGS, v);
			apb(1'b1, OFF_INSTR, {OPC_FLAG_HI, i[3:0], OPC_FLAG_LO});
			apb(1'b0, OFF_FLAGS, 0);
			chk(rdat[7:0], v | {i[3:0], 4'h0}, "flags");
		end
		apb(1'b1, OFF_INSTR, 32'h8DF0);
		apb(1'b0, OFF_STATUS, 0);
		chk(rdat[ST_ILLEGAL], 1, "illegal word");
		apb(1'b1, OFF_STATUS, ST_ILLEGAL_MASK);
		// Random static and dynamic bit sets in all three sizes.
		for (k = 0; k < 30; k++) begin
			sz = $urandom_range(2);
			rd = $urandom_range(15);
			dyn = $urandom_range(1);
			rs = (rd + 1) % 16;
			t = (sz == 0 && rd >= 8) ? rd - 8 : rd;
			g[t] = $urandom;
			g[rs] = $urandom;
			apb(1'b1, {GPR_WIN, t[3:0], 2'h0}, g[t]);
			apb(1'b1, {GPR_WIN, rs[3:0], 2'h0}, g[rs]);
			bn = dyn ? g[rs] : $urandom;
			bn &= (sz == 0) ? 7 : (sz == 1) ? 15 : 31;
			pos = bn + ((sz == 0 && rd < 8) ? 8 : 0);
			if (sz == 2) apb(1'b1, OFF_INSTR, {OPC_LONG_PFX, 8'h02});
			if (dyn) begin
				apb(1'b1, OFF_INSTR, {OPC_SET_IR, sz != 0, 4'h0, rs[3:0]});
				apb(1'b1, OFF_INSTR, {4'h0, rd[3:0], 8'h00});
			end else begin
				apb(1'b1, OFF_INSTR, {OPC_SET_R, (sz == 2) ? bn[4] : sz == 1, rd[3:0], bn[3:0]});
			end
			idle();
			g[t] |= 32'h1 << pos;
			apb(1'b0, {GPR_WIN, t[3:0], 2'h0}, 0);
			chk(rdat, g[t], "bit set register");
		end
		// Pointer width follows the mode.
		for (i = 0; i < 3; i++) begin
			v = $urandom;
			o = $urandom;
			bn = $urandom_range(15);
			apb(1'b1, {GPR_WIN, 4'h3, 2'h0}, v);
			apb(1'b1, OFF_MODE, i);
			apb(1'b1, OFF_MEM_OPND, o);
			apb(1'b1, OFF_INSTR, {OPC_SET_IR, 1'b1, 4'h3, bn[3:0]});
			idle();
			chk(rdat[ST_PTR_LONG], i != 0, "pointer long");
			apb(1'b0, OFF_EA, 0);
			chk(rdat, i == 0 ? {16'h0, v[15:0]} : v, "pointer");
			apb(1'b0, OFF_MEM_RES, 0);
			chk(rdat, o | 32'h1 << bn, "memory result");
		end
		// General operand with each extension count.
		for (i = 0; i < 4; i++) begin
			o = $urandom;
			bn = $urandom_range(15);
			apb(1'b1, OFF_MEM_OPND, o);
			apb(1'b1, OFF_INSTR, {OPC_SET_EAM, 1'b1, 2'h0, i[1:0], bn[3:0]});
			// Bit 15 stays clear so no extension word looks like a flag-mask word to the checker's shadow.
			for (k = 0; k < ((i == 0) ? 1 : i); k++) apb(1'b1, OFF_INSTR, $urandom & 32'h7FFF);
			idle();
			chk(rdat[9:8], (i == 0) ? 1 : i, "extension count");
			apb(1'b0, OFF_MEM_RES, 0);
			chk(rdat, o | 32'h1 << bn, "general result");
		end
		apb(1'b0, 8'h20, 0);
		chk(rerr, 1, "hole read error");
		chk(rdat, 0, "hole read data");
		// The hole at 0x84 would alias register 1 if the window decode ignored the top address bits.
		apb(1'b1, {GPR_WIN, 4'h1, 2'h0}, 0);
		apb(1'b1, 8'h84, 32'hFFFF);
		chk(rerr, 1, "hole write");
		apb(1'b0, {GPR_WIN, 4'h1, 2'h0}, 0);
		chk(rdat, 0, "hole write effect");
		give_verdict();
	end
endmodule : bitset_decode_tb
`default_nettype wire
